// ==== design/splk_regs.svh ====
`ifndef SPLK_REGS_SVH
`define SPLK_REGS_SVH
// ----------------------------------------
// partition lock constants
// ----------------------------------------
// default number of downstream ports in the partition
`define SPLK_NUM_DS 8
// reset value of the locked-port mask
`define SPLK_MASK_RST 1'b0
`endif

// ==== design/splk_pkg.sv ====
`default_nettype none
package splk_pkg;
  // lock sequence states
  typedef enum logic [2:0] {
    SPLK_IDLE,
    SPLK_RD_PEND,
    SPLK_DS_LOCKED,
    SPLK_CPL_PEND,
    SPLK_BUS_LOCKED,
    SPLK_UNL_PEND
  } splk_state_t;
  // tlp classes seen on the upstream ingress
  typedef enum logic [1:0] {
    SPLK_US_MWR,
    SPLK_US_MRDLK,
    SPLK_US_UNLOCK,
    SPLK_US_OTHER
  } splk_us_kind_t;
  // tlp classes seen on a downstream ingress
  typedef enum logic [1:0] {
    SPLK_DS_CPLDLK,
    SPLK_DS_CPLLK,
    SPLK_DS_OTHER
  } splk_ds_kind_t;
endpackage : splk_pkg
`default_nettype wire

// ==== design/splk_lock.sv ====
`include "splk_regs.svh"
`default_nettype none
module splk_lock
  import splk_pkg::*;
#(
  parameter int NUM_DS = `SPLK_NUM_DS,
  parameter int PW = (NUM_DS > 1) ? $clog2(NUM_DS) : 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // upstream ingress tlp classifier
  input wire logic us_rx_valid,
  input wire splk_us_kind_t us_rx_kind,
  input wire logic [PW-1:0] us_rx_dest,
  // downstream ingress tlp classifier
  input wire logic ds_rx_valid,
  input wire splk_ds_kind_t ds_rx_kind,
  input wire logic [PW-1:0] ds_rx_port,
  // posted queue drain flags
  input wire logic [NUM_DS-1:0] ds_egr_post_empty,
  input wire logic [NUM_DS-1:0] ds_to_us_post_empty,
  input wire logic us_post_empty,
  // forwarding query from the switch core
  input wire logic q_valid,
  input wire logic q_own,
  input wire logic q_vc0,
  input wire logic q_src_us,
  input wire logic [PW-1:0] q_src_ds,
  input wire logic q_dst_us,
  input wire logic [PW-1:0] q_dst_ds,
  output logic q_hold,
  // locked traffic release strobes and locked port index
  output logic mrdlk_go_q,
  output logic cpl_go_q,
  output logic unlock_go_q,
  output logic relay_q,
  output logic [PW-1:0] lock_port_q,
  // lock state
  output logic [NUM_DS-1:0] ds_lock_q,
  output logic us_lock_q,
  output logic bus_locked_q
);

  // ----------------------------------------
  // decode
  // ----------------------------------------
  splk_state_t state_q;
  splk_state_t state_d;
  logic [PW-1:0] port_d;

  // one-hot of a port index, used for lock mask and checks
  function automatic logic [NUM_DS-1:0] splk_onehot(input logic [PW-1:0] idx);
    logic [NUM_DS-1:0] v;
    v = '0;
    v[idx] = 1'b1;
    return v;
  endfunction : splk_onehot

  wire us_mrdlk = us_rx_valid && (us_rx_kind == SPLK_US_MRDLK);
  wire us_unlock = us_rx_valid && (us_rx_kind == SPLK_US_UNLOCK);
  wire us_mwr = us_rx_valid && (us_rx_kind == SPLK_US_MWR);
  wire ds_from_lk = ds_rx_valid && (ds_rx_port == lock_port_q);
  wire ds_cpldlk = ds_from_lk && (ds_rx_kind == SPLK_DS_CPLDLK);
  wire ds_cpllk = ds_from_lk && (ds_rx_kind == SPLK_DS_CPLLK);
  wire rd_drained = ds_egr_post_empty[lock_port_q];
  wire cpl_drained = ds_to_us_post_empty[lock_port_q];
  // locked states: unlock has effect only here
  wire locked_st = (state_q == SPLK_DS_LOCKED) || (state_q == SPLK_CPL_PEND) ||
                   (state_q == SPLK_BUS_LOCKED);

  // ----------------------------------------
  // lock sequence
  // ----------------------------------------
  // next-state; mrdlk while busy is not a new sequence
  always_comb begin
    state_d = state_q;
    port_d = lock_port_q;
    case (state_q)
      SPLK_IDLE: begin
        if (us_mrdlk) begin
          state_d = SPLK_RD_PEND;
          port_d = us_rx_dest;
        end
      end
      SPLK_RD_PEND: begin
        // unlock here finds nothing locked yet and falls through
        // completions may be bypassed, only posted must drain
        if (rd_drained) begin
          state_d = SPLK_DS_LOCKED;
        end
      end
      SPLK_DS_LOCKED: begin
        if (us_unlock) begin
          state_d = SPLK_UNL_PEND;
        end else if (ds_cpldlk) begin
          state_d = SPLK_CPL_PEND;
        end
      end
      SPLK_CPL_PEND: begin
        // queued non-posted requests may be bypassed
        if (us_unlock) begin
          state_d = SPLK_UNL_PEND;
        end else if (cpl_drained) begin
          state_d = SPLK_BUS_LOCKED;
        end
      end
      SPLK_BUS_LOCKED: begin
        // writes, reads and completions keep the state
        if (us_unlock) begin
          state_d = SPLK_UNL_PEND;
        end
      end
      SPLK_UNL_PEND: begin
        if (us_post_empty) begin
          state_d = SPLK_IDLE;
        end
      end
      default: begin
        state_d = SPLK_IDLE;
      end
    endcase
  end

  wire to_ds_lock = (state_q == SPLK_RD_PEND) && (state_d == SPLK_DS_LOCKED);
  wire to_bus_lock = (state_q == SPLK_CPL_PEND) && (state_d == SPLK_BUS_LOCKED);
  wire to_idle = (state_q == SPLK_UNL_PEND) && (state_d == SPLK_IDLE);
  // follow-up locked traffic in bus lock is passed straight through
  wire relay_d = (state_q == SPLK_BUS_LOCKED) && !us_unlock &&
                 ((us_mrdlk && (us_rx_dest == lock_port_q)) || ds_cpldlk || ds_cpllk);
  // ds lock mask: set once the read is sent, dropped at final unlock
  wire [NUM_DS-1:0] ds_lock_d = to_ds_lock ? splk_onehot(lock_port_q) :
                                to_idle ? '0 : ds_lock_q;
  wire us_lock_d = to_bus_lock ? 1'b1 : (to_idle ? 1'b0 : us_lock_q);

  // state and port index
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= SPLK_IDLE;
      lock_port_q <= '0;
    end else begin
      state_q <= state_d;
      lock_port_q <= port_d;
    end
  end

  // lock flags and release strobes
  always_ff @(posedge clk) begin
    if (srst) begin
      ds_lock_q <= {NUM_DS{`SPLK_MASK_RST}};
      us_lock_q <= `SPLK_MASK_RST;
      bus_locked_q <= `SPLK_MASK_RST;
      mrdlk_go_q <= 1'b0;
      cpl_go_q <= 1'b0;
      unlock_go_q <= 1'b0;
      relay_q <= 1'b0;
    end else begin
      ds_lock_q <= ds_lock_d;
      us_lock_q <= us_lock_d;
      bus_locked_q <= us_lock_d;
      mrdlk_go_q <= to_ds_lock;
      cpl_go_q <= to_bus_lock;
      unlock_go_q <= to_idle;
      relay_q <= relay_d;
    end
  end

  // ----------------------------------------
  // forwarding hold
  // ----------------------------------------
  // hold is a stall, never a drop; timeouts belong to the core
  wire hit_ds = !q_dst_us && ds_lock_q[q_dst_ds] && !q_src_us;
  wire hit_us = q_dst_us && us_lock_q &&
                !(!q_src_us && (q_src_ds == lock_port_q));
  // own messages and msi are never held; side-band access is not routed here
  assign q_hold = q_valid && q_vc0 && !q_own && (hit_ds || hit_us);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_unlock_in_lock;
    us_unlock && locked_st;
  endsequence
  sequence s_drain;
    us_post_empty [*2];
  endsequence

  AST_ONE_SEQ: assert property (
    us_mrdlk && (state_q != SPLK_IDLE) |=> $stable(lock_port_q))
    else $error("second lock sequence changed the locked port");
  AST_DS_LOCK: assert property (
    mrdlk_go_q |-> ds_lock_q == splk_onehot(lock_port_q) && !us_lock_q)
    else $error("locked read sent without locking its port");
  AST_VC_PASS: assert property (
    q_valid && !q_vc0 |-> !q_hold)
    else $error("non-vc0 tlp held by lock");
  AST_RD_ORDER: assert property (
    mrdlk_go_q |-> $past(ds_egr_post_empty[lock_port_q]))
    else $error("locked read overtook posted requests");
  AST_OTHER_FLOW: assert property (
    q_valid && !q_dst_us && (q_dst_ds != lock_port_q) |-> !q_hold)
    else $error("traffic to unlocked port held");
  AST_US_LOCK: assert property (
    cpl_go_q |-> us_lock_q ##1 us_lock_q || unlock_go_q)
    else $error("upstream not locked after locked completion");
  AST_CPL_ORDER: assert property (
    $rose(cpl_go_q) |-> $past(ds_to_us_post_empty[lock_port_q]))
    else $error("locked completion overtook posted requests");
  AST_BUS_LOCK: assert property (
    bus_locked_q |-> us_lock_q && (ds_lock_q != '0))
    else $error("bus-locked without both ends locked");
  AST_BUS_STAY: assert property (
    bus_locked_q && (state_q == SPLK_BUS_LOCKED) && !us_unlock |=> bus_locked_q)
    else $error("lock dropped without unlock");
  AST_UNLOCK: assert property (
    s_unlock_in_lock ##1 s_drain |-> ##[0:2] unlock_go_q ##1 (ds_lock_q == '0) && !us_lock_q)
    else $error("unlock did not release the partition");
  AST_UNL_WAIT: assert property (
    unlock_go_q |-> $past(us_post_empty))
    else $error("unlock released before posted drain");
  AST_IDLE_UNLOCK: assert property (
    (state_q == SPLK_IDLE) && us_unlock |=> (state_q == SPLK_IDLE) && !unlock_go_q)
    else $error("unlock on unlocked port changed state");
  AST_OWN_MSG: assert property (
    q_valid && q_own |-> !q_hold)
    else $error("inserted message held by lock");
  AST_HOLD_ONLY_LOCKED: assert property (
    q_hold |-> (ds_lock_q != '0))
    else $error("tlp held while nothing locked");
  AST_RESET: assert property (@(posedge clk) disable iff (1'b0)
    srst |=> (ds_lock_q == '0) && !us_lock_q && !bus_locked_q && !q_hold)
    else $error("lock state survived reset");

  // ----------------------------------------
  // sequence and hold checks
  // ----------------------------------------
  // a fresh locked read taken while the partition is free
  sequence s_rd_start;
    us_mrdlk && (state_q == SPLK_IDLE);
  endsequence
  // the target egress has no posted request left
  sequence s_rd_sent;
    (state_q == SPLK_RD_PEND) && rd_drained;
  endsequence
  // locked completion with data from the locked port, no abort beside it
  sequence s_cpl_start;
    ds_cpldlk && !us_unlock && (state_q == SPLK_DS_LOCKED);
  endsequence
  // posted traffic toward upstream has drained, still no abort
  sequence s_cpl_sent;
    (state_q == SPLK_CPL_PEND) && cpl_drained && !us_unlock;
  endsequence
  // a follow-up locked tlp seen during bus lock
  sequence s_follow_up;
    (state_q == SPLK_BUS_LOCKED) && !us_unlock && (ds_cpldlk || ds_cpllk);
  endsequence

  // one port at most, and always the one whose index is kept
  AST_ONE_PORT: assert property (
    (ds_lock_q != '0) |-> (ds_lock_q == splk_onehot(lock_port_q)))
    else $error("more than one downstream port locked");

  // read is sent and its port locked once posted traffic has left
  AST_RD_SEQ: assert property (
    s_rd_start ##1 s_rd_sent |=> mrdlk_go_q && ds_lock_q[lock_port_q])
    else $error("locked read not released after drain");

  // a queued posted request keeps the read back and the port free
  AST_RD_WAIT: assert property (
    (state_q == SPLK_RD_PEND) && !rd_drained |=> !mrdlk_go_q && (ds_lock_q == '0))
    else $error("locked read released over queued posted requests");

  // completion path: forwarded after drain, upstream locked with it
  AST_CPL_SEQ: assert property (
    s_cpl_start ##1 s_cpl_sent |=> cpl_go_q && us_lock_q && bus_locked_q)
    else $error("locked completion did not lock the upstream port");
  AST_CPL_WAIT: assert property (
    (state_q == SPLK_CPL_PEND) && !cpl_drained |=> !cpl_go_q && !us_lock_q)
    else $error("locked completion released over queued posted requests");

  // the hold must actually bite, not only stay quiet elsewhere
  AST_HOLD_DS: assert property (
    q_valid && q_vc0 && !q_own && !q_src_us && !q_dst_us && (ds_lock_q != '0) &&
    (q_dst_ds == lock_port_q) |-> q_hold)
    else $error("vc0 tlp to locked port not held");
  AST_HOLD_US: assert property (
    q_valid && q_vc0 && !q_own && q_dst_us && bus_locked_q && !q_src_us &&
    (q_src_ds != lock_port_q) |-> q_hold)
    else $error("vc0 tlp to locked upstream port not held");

  // a completion without data never ends the lock before bus lock
  AST_CPLLK_KEEP: assert property (
    (state_q == SPLK_DS_LOCKED) && ds_cpllk && !us_unlock |=>
    (state_q == SPLK_DS_LOCKED))
    else $error("completion without data moved the lock");
  AST_RELAY: assert property (
    s_follow_up |=> relay_q && bus_locked_q)
    else $error("follow-up locked tlp not passed during bus lock");

  // writes to the locked device pass through untouched
  AST_MWR_KEEP: assert property (
    us_mwr && (state_q == SPLK_BUS_LOCKED) |=> bus_locked_q && $stable(ds_lock_q))
    else $error("memory write changed the bus lock");

  // unlock waits on the upstream posted queue, then frees both ends
  AST_UNL_HOLD: assert property (
    (state_q == SPLK_UNL_PEND) && !us_post_empty |=> !unlock_go_q && (ds_lock_q != '0))
    else $error("unlock released with upstream posted traffic queued");
  AST_RELEASE: assert property (
    unlock_go_q |-> (ds_lock_q == '0) && !us_lock_q && !bus_locked_q &&
    (state_q == SPLK_IDLE))
    else $error("unlock left a port locked");

  // unlock before the read has gone out finds nothing locked
  AST_EARLY_UNLOCK: assert property (
    (state_q == SPLK_RD_PEND) && us_unlock |=> (state_q != SPLK_UNL_PEND))
    else $error("unlock acted on a port not yet locked");

  // nothing is held once the partition is free again
  AST_FREE_PASS: assert property (
    (state_q == SPLK_IDLE) |-> !q_hold)
    else $error("tlp held while partition free");

endmodule : splk_lock
`default_nettype wire

// ==== testbench/splk_far_model.sv ====
`default_nettype none
// ----------------------------------------
// root complex and legacy endpoint model
// ----------------------------------------
module splk_far_model
  import splk_pkg::*;
(
  // clock
  input wire logic clk,
  // root requests on the upstream link
  output var logic us_rx_valid,
  output var splk_us_kind_t us_rx_kind,
  output var logic [2:0] us_rx_dest,
  // endpoint completions on a downstream link
  output var logic ds_rx_valid,
  output var splk_ds_kind_t ds_rx_kind,
  output var logic [2:0] ds_rx_port
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle links at time zero
  initial begin
    us_rx_valid = 1'b0;
    us_rx_kind = SPLK_US_OTHER;
    us_rx_dest = 3'h0;
    ds_rx_valid = 1'b0;
    ds_rx_kind = SPLK_DS_OTHER;
    ds_rx_port = 3'h0;
  end
  // root keeps to mwr, mrdlk and unlock; no config access
  task automatic us_send(input splk_us_kind_t k, input logic [2:0] d);
    @(posedge clk);
    us_rx_valid <= 1'b1;
    us_rx_kind <= k;
    us_rx_dest <= d;
    @(posedge clk);
    us_rx_valid <= 1'b0;
    us_rx_dest <= ~d; // stale field must not be trusted
  endtask : us_send
  // endpoint answers only with locked completions
  task automatic ds_send(input splk_ds_kind_t k, input logic [2:0] p);
    @(posedge clk);
    ds_rx_valid <= 1'b1;
    ds_rx_kind <= k;
    ds_rx_port <= p;
    @(posedge clk);
    ds_rx_valid <= 1'b0;
    ds_rx_port <= ~p;
  endtask : ds_send
endmodule : splk_far_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
`default_nettype none
module tb_top
  import splk_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // bench signals
  // ----------------------------------------
  logic clk = 1'b0, srst = 1'b1, uv, dv, us_pe = 1'b1, q_valid = 1'b0;
  logic q_own = 1'b0, q_vc0 = 1'b0, q_src_us = 1'b0, q_dst_us = 1'b0;
  logic [2:0] ud, dp, q_src_ds = 3'h0, q_dst_ds = 3'h0, lock_port_q;
  logic [7:0] egr_e = 8'hff, tous_e = 8'hff, ds_lock_q;
  logic q_hold, mrdlk_go_q, cpl_go_q, unlock_go_q, us_lock_q, bus_locked_q, relay_q;
  splk_us_kind_t uk;
  splk_ds_kind_t dk;
  int miscompares = 0, n_tests = 0;
  wire logic [2:0] go_v = {unlock_go_q, cpl_go_q, mrdlk_go_q};
  always #5 clk = ~clk;
  splk_far_model splk_far_model_inst (.clk(clk), .us_rx_valid(uv),
    .us_rx_kind(uk), .us_rx_dest(ud), .ds_rx_valid(dv), .ds_rx_kind(dk),
    .ds_rx_port(dp));
  splk_lock splk_lock_inst (.clk(clk), .srst(srst), .us_rx_valid(uv),
    .us_rx_kind(uk), .us_rx_dest(ud), .ds_rx_valid(dv), .ds_rx_kind(dk),
    .ds_rx_port(dp), .ds_egr_post_empty(egr_e), .ds_to_us_post_empty(tous_e),
    .us_post_empty(us_pe), .q_valid(q_valid), .q_own(q_own), .q_vc0(q_vc0),
    .q_src_us(q_src_us), .q_src_ds(q_src_ds), .q_dst_us(q_dst_us),
    .q_dst_ds(q_dst_ds), .q_hold(q_hold), .mrdlk_go_q(mrdlk_go_q),
    .cpl_go_q(cpl_go_q), .unlock_go_q(unlock_go_q), .relay_q(relay_q),
    .lock_port_q(lock_port_q), .ds_lock_q(ds_lock_q), .us_lock_q(us_lock_q),
    .bus_locked_q(bus_locked_q));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // bounded wait for one release strobe; a miss ends the run
  task automatic wgo(input int w);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      if (go_v[w] === 1'b1) return;
    end
    chk("go strobe", 8'h01, 8'h00);
    end_sim();
  endtask : wgo
  // query fields: own, vc0, src_us, src, dst_us, dst
  task automatic hq(input logic [9:0] v, input logic e);
    @(posedge clk);
    {q_own, q_vc0, q_src_us, q_src_ds, q_dst_us, q_dst_ds} <= v;
    q_valid <= 1'b1;
    @(negedge clk);
    chk("q_hold", {7'h00, e}, {7'h00, q_hold});
  endtask : hq
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_lock();
    egr_e <= 8'hf7; // a posted write is still queued at port 3
    splk_far_model_inst.us_send(SPLK_US_MRDLK, 3'h3);
    splk_far_model_inst.us_send(SPLK_US_UNLOCK, 3'h3);
    repeat (4) @(negedge clk);
    chk("mrdlk_go_q", 8'h00, {7'h00, mrdlk_go_q});
    @(posedge clk);
    egr_e <= 8'hff;
    wgo(0);
    chk("ds_lock_q", 8'h08, ds_lock_q);
    splk_far_model_inst.us_send(SPLK_US_MRDLK, 3'h5);
    repeat (3) @(negedge clk);
    chk("lock_port_q", 8'h03, {5'h00, lock_port_q});
    hq(10'h113, 1'b1);
    hq(10'h183, 1'b0);
    hq(10'h013, 1'b0);
    hq(10'h112, 1'b0);
    hq(10'h313, 1'b0);
  endtask : t_lock
  task automatic t_cpl();
    @(posedge clk);
    tous_e <= 8'hf7;
    splk_far_model_inst.ds_send(SPLK_DS_CPLDLK, 3'h3);
    repeat (4) @(negedge clk);
    chk("bus_locked_q", 8'h00, {7'h00, bus_locked_q});
    @(posedge clk);
    tous_e <= 8'hff;
    wgo(1);
    chk("us_lock_q", 8'h01, {7'h00, us_lock_q});
    chk("bus_locked_q", 8'h01, {7'h00, bus_locked_q});
    hq(10'h118, 1'b1);
    hq(10'h138, 1'b0);
    hq(10'h112, 1'b0);
  endtask : t_cpl
  task automatic t_bus();
    splk_far_model_inst.us_send(SPLK_US_MRDLK, 3'h3);
    @(negedge clk);
    chk("relay_q", 8'h01, {7'h00, relay_q});
    splk_far_model_inst.ds_send(SPLK_DS_CPLLK, 3'h3);
    @(negedge clk);
    chk("relay_q", 8'h01, {7'h00, relay_q});
    splk_far_model_inst.us_send(SPLK_US_MWR, 3'h3);
    @(negedge clk);
    chk("relay_q", 8'h00, {7'h00, relay_q});
    repeat (2) @(negedge clk);
    chk("bus_locked_q", 8'h01, {7'h00, bus_locked_q});
    chk("ds_lock_q", 8'h08, ds_lock_q);
  endtask : t_bus
  task automatic t_unlock();
    @(posedge clk);
    us_pe <= 1'b0; // upstream posted queue not yet drained
    splk_far_model_inst.us_send(SPLK_US_UNLOCK, 3'h3);
    repeat (4) @(negedge clk);
    chk("bus_locked_q", 8'h01, {7'h00, bus_locked_q});
    hq(10'h118, 1'b1);
    @(posedge clk);
    us_pe <= 1'b1;
    wgo(2);
    chk("locks", 8'h00, ds_lock_q | {7'h00, us_lock_q | bus_locked_q});
    hq(10'h113, 1'b0);
    splk_far_model_inst.us_send(SPLK_US_UNLOCK, 3'h5);
    repeat (3) begin
      @(negedge clk);
      chk("unlock_go_q", 8'h00, {7'h00, unlock_go_q});
    end
    chk("ds_lock_q", 8'h00, ds_lock_q);
  endtask : t_unlock
  task automatic t_reset();
    splk_far_model_inst.us_send(SPLK_US_MRDLK, 3'h2);
    wgo(0);
    splk_far_model_inst.ds_send(SPLK_DS_CPLDLK, 3'h2);
    wgo(1);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    chk("locks", 8'h00, ds_lock_q | {7'h00, us_lock_q | bus_locked_q});
    chk("go_v", 8'h00, {5'h00, go_v});
    hq(10'h112, 1'b0);
    splk_far_model_inst.us_send(SPLK_US_MRDLK, 3'h4);
    wgo(0);
    chk("ds_lock_q", 8'h10, ds_lock_q);
    splk_far_model_inst.ds_send(SPLK_DS_CPLLK, 3'h4);
    repeat (2) @(negedge clk);
    chk("us_lock_q", 8'h00, {7'h00, us_lock_q});
    splk_far_model_inst.us_send(SPLK_US_UNLOCK, 3'h4);
    wgo(2);
    chk("ds_lock_q", 8'h00, ds_lock_q);
  endtask : t_reset
  // main sequence: reset held three cycles
  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_lock();
    t_cpl();
    t_bus();
    t_unlock();
    t_reset();
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
